// >>> src/mcsf_pkg.sv
// shared constants and carrier types of the mac client block
package mcsf_pkg;
   // register port
   localparam int unsigned ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_MAXLEN = 4'h4;
   localparam logic [ADDR_W-1:0] REG_REFRESH = 4'h8;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'hC;
   localparam int unsigned CTRL_TWO_BIT = 0;
   localparam int unsigned CTRL_PASSTHRU = 1;
   localparam int unsigned STATUS_BUSY = 8;
   localparam logic [15:0] MAXLEN_RST = 16'h05EE;
   localparam logic [15:0] REFRESH_RST = 16'h0FFF;
   // frame check arithmetic
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_RESID = 32'hDEBB20E3;
   localparam logic [15:0] LEN_TYPE_LIMIT = 16'h0600;
   localparam logic [15:0] HDR_FCS_BYTES = 16'h0012;
   localparam logic [3:0] FCS_BYTES = 4'h4;
   localparam logic [3:0] WORD_BYTES = 4'h8;
   localparam logic [3:0] STRIP_BASE = 4'hC;
   localparam logic [1:0] LEN_WORD = 2'h1;
   localparam int unsigned LEN_HI_LANE = 4;
   localparam int unsigned LEN_LO_LANE = 5;
   // error vector positions
   localparam int unsigned RXE_LEN = 4;
   localparam int unsigned RXE_OVER = 3;
   localparam int unsigned RXE_CRC = 1;
   localparam int unsigned RXE_MALF = 0;
   localparam int unsigned TXE_LEN = 2;
   localparam int unsigned TXE_OVER = 1;
   // one finished transmit frame, frame kind bits in status order
   typedef struct packed {
      logic pfc;
      logic unicast;
      logic multicast;
      logic broadcast;
      logic pause;
      logic control;
      logic vlan;
      logic stacked_vlan;
      logic [15:0] frame_len;
      logic [15:0] payload_len;
      logic len_err;
      logic oversize;
   } mcsf_tx_info_t;
   // decoded receive word in line order, byte 0 in bits 7:0
   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic bad_term;
      logic [3:0] nbytes;
      logic [63:0] data;
   } mcsf_rx_line_t;
   // client receive stream
   typedef struct packed {
      logic rx_word_valid;
      logic rx_frame_start_marker;
      logic rx_frame_end_marker;
      logic [2:0] rx_unused_byte_count;
      logic [5:0] rx_frame_error_vector;
      logic [63:0] rx_client_word;
   } mcsf_rx_stream_t;
endpackage

// >>> src/mcsf_client.sv
// mac client logic: tx status, flow control requests, rx stream
// What this block does
// - tx status top byte flags frame kind
// - tx status bits 31:16 give frame length
// - tx status low half gives payload length
// - tx error vector: bit2 length, bit1 oversize
// - one request bit per queue, one to eight
// - one-bit mode ignores the high request input
// - one-bit: rise xoff, held xoff, fall xon
// - two-bit: 00 stop, 01 xon, 10 xoff, 11 never
// - rx words 64 bits, all on one clock
// - rx clock stable whenever coding layer ready
// - earliest received byte in highest lane
// - valid continuous through packet without fec
// - start marker on first byte's cycle
// - end marker before check, or last check byte
// - unused low lanes counted at end marker
// - rx error vector meaningful only at end
// - oversize when frame exceeds programmed maximum
// - error bit 1 on check value mismatch
// - bad terminate sets malformed and check error
// - bits 4 length, 3 oversize, 1 check, 0 malformed
module mcsf_client
   import mcsf_pkg::*;
#(
   parameter int unsigned FLOW_QUEUE_COUNT = 1
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // transmit status from the tx mac
   input wire logic tx_info_valid,
   input wire mcsf_tx_info_t tx_info,
   output logic [39:0] tx_frame_status_word,
   output logic [6:0] tx_frame_error_vector,
   // flow control requests and pause generator strobes
   input wire logic [FLOW_QUEUE_COUNT-1:0] flow_ctrl_request_low,
   input wire logic [FLOW_QUEUE_COUNT-1:0] flow_ctrl_request_high,
   output logic [FLOW_QUEUE_COUNT-1:0] fc_xoff_pulse,
   output logic [FLOW_QUEUE_COUNT-1:0] fc_xon_pulse,
   // receive line side and client stream
   input wire mcsf_rx_line_t rx_line,
   output mcsf_rx_stream_t rx_stream
);

   localparam int unsigned FQ = FLOW_QUEUE_COUNT;

   generate
      if (FQ < 1 || FQ > 8) begin : g_bad_fq
         $error("flow queue count must be 1 to 8");
      end
   endgenerate

   function automatic logic [31:0] crc_upd(input logic [31:0] c,
                                           input logic [63:0] d,
                                           input logic [3:0] n);
      logic [31:0] r;
      logic fb;
      r = c;
      fb = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < n) begin
            for (int j = 0; j < 8; j++) begin
               fb = r[0] ^ d[8*i+j];
               r = (r >> 1) ^ (fb ? CRC_POLY : 32'h00000000);
            end
         end
      end
      return r;
   endfunction

   function automatic logic [63:0] rev(input logic [63:0] d);
      logic [63:0] r;
      r = 64'h0000000000000000;
      for (int i = 0; i < 8; i++) begin
         r[8*i+:8] = d[8*(7-i)+:8];
      end
      return r;
   endfunction

   // control registers
   logic two_bit_ff;
   logic passthru_ff;
   logic [15:0] maxlen_ff;
   logic [15:0] refresh_ff;
   logic [31:0] rdata_ff;
   // flow control state
   logic [FQ-1:0] prev_low_ff;
   logic [FQ-1:0] prev_high_ff;
   logic [FQ-1:0] act_ff;
   logic [FQ-1:0] xoff_ff;
   logic [FQ-1:0] xon_ff;
   logic [15:0] rf_cnt_ff;
   logic rf_hit;
   // tx status
   logic [39:0] tx_status_ff;
   logic [6:0] tx_err_ff;
   // rx state
   logic [31:0] crc_ff;
   logic [15:0] cnt_ff;
   logic [15:0] len_ff;
   logic [1:0] widx_ff;
   logic rx_busy_ff;
   logic hold_vld_ff;
   logic hold_sof_ff;
   logic hold_end_ff;
   logic [2:0] hold_empty_ff;
   logic [5:0] hold_err_ff;
   logic [63:0] hold_data_ff;
   mcsf_rx_stream_t rx_out_ff;
   // rx next values
   logic [31:0] nxt_crc;
   logic [15:0] nxt_cnt;
   logic [5:0] nxt_err;
   logic strip;
   logic emit;

   assign reg_rdata = rdata_ff;
   assign tx_frame_status_word = tx_status_ff;
   assign tx_frame_error_vector = tx_err_ff;
   assign fc_xoff_pulse = xoff_ff;
   assign fc_xon_pulse = xon_ff;
   assign rx_stream = rx_out_ff;

   // register writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         two_bit_ff <= 1'b0;
         passthru_ff <= 1'b0;
         maxlen_ff <= MAXLEN_RST;
         refresh_ff <= REFRESH_RST;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            REG_CTRL: begin
               two_bit_ff <= reg_wdata[CTRL_TWO_BIT];
               passthru_ff <= reg_wdata[CTRL_PASSTHRU];
            end
            REG_MAXLEN: maxlen_ff <= reg_wdata[15:0];
            REG_REFRESH: refresh_ff <= reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // register reads, data only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_ff <= 32'h00000000;
      end else if (ce) begin
         rdata_ff <= 32'h00000000;
         if (reg_rd) begin
            case (reg_addr)
               REG_CTRL: rdata_ff <= 32'({passthru_ff, two_bit_ff});
               REG_MAXLEN: rdata_ff <= 32'(maxlen_ff);
               REG_REFRESH: rdata_ff <= 32'(refresh_ff);
               REG_STATUS: begin
                  rdata_ff <= 32'(act_ff) |
                              (32'(rx_busy_ff) << STATUS_BUSY);
               end
               default: rdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // transmit status capture
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_status_ff <= 40'h0000000000;
         tx_err_ff <= 7'h00;
      end else if (ce && tx_info_valid) begin
         tx_status_ff <= {tx_info.pfc, tx_info.unicast,
                          tx_info.multicast, tx_info.broadcast,
                          tx_info.pause, tx_info.control,
                          tx_info.vlan, tx_info.stacked_vlan,
                          tx_info.frame_len,
                          tx_info.payload_len};
         tx_err_ff <= 7'h00;
         tx_err_ff[TXE_LEN] <= tx_info.len_err;
         tx_err_ff[TXE_OVER] <= tx_info.oversize;
      end
   end

   // xoff refresh timer, shared by all queues
   assign rf_hit = (rf_cnt_ff == 16'h0000);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rf_cnt_ff <= REFRESH_RST;
      end else if (ce) begin
         rf_cnt_ff <= rf_hit ? refresh_ff : rf_cnt_ff - 16'h0001;
      end
   end

   // flow control request decode
   always_ff @(posedge ref_clk) begin
      logic [1:0] code;
      logic [1:0] pcode;
      logic nact;
      logic xon;
      logic xoff;
      if (rst) begin
         prev_low_ff <= '0;
         prev_high_ff <= '0;
         act_ff <= '0;
         xoff_ff <= '0;
         xon_ff <= '0;
      end else if (ce) begin
         for (int q = 0; q < FQ; q++) begin
            nact = act_ff[q];
            xon = 1'b0;
            xoff = 1'b0;
            code = {flow_ctrl_request_high[q],
                    flow_ctrl_request_low[q]};
            pcode = {prev_high_ff[q], prev_low_ff[q]};
            if (!two_bit_ff) begin
               // high input is never looked at here
               nact = flow_ctrl_request_low[q];
               xoff = flow_ctrl_request_low[q] & ~prev_low_ff[q];
               xon = ~flow_ctrl_request_low[q] & prev_low_ff[q];
            end else begin
               case (code)
                  2'b10: begin
                     nact = 1'b1;
                     xoff = (code != pcode);
                  end
                  2'b01: begin
                     nact = 1'b0;
                     xon = (code != pcode);
                  end
                  2'b00: nact = 1'b0;
                  // invalid code: keep state rather than guess
                  default: nact = act_ff[q];
               endcase
            end
            // held xoff keeps asking at the refresh interval
            xoff = xoff | (rf_hit & nact & act_ff[q]);
            act_ff[q] <= nact;
            xoff_ff[q] <= xoff;
            xon_ff[q] <= xon;
         end
         prev_low_ff <= flow_ctrl_request_low;
         prev_high_ff <= flow_ctrl_request_high;
      end
   end

   // end-of-frame checks on the incoming word
   always_comb begin
      nxt_crc = crc_upd(rx_line.sof ? CRC_INIT : crc_ff,
                        rx_line.data, rx_line.nbytes);
      nxt_cnt = (rx_line.sof ? 16'h0000 : cnt_ff) +
                {12'h000, rx_line.nbytes};
      nxt_err = 6'h00;
      nxt_err[RXE_CRC] = (nxt_crc != CRC_RESID);
      if (rx_line.bad_term) begin
         nxt_err[RXE_MALF] = 1'b1;
         nxt_err[RXE_CRC] = 1'b1;
      end
      nxt_err[RXE_OVER] = (nxt_cnt > maxlen_ff);
      nxt_err[RXE_LEN] = (len_ff < LEN_TYPE_LIMIT) &&
                         (nxt_cnt < len_ff + HDR_FCS_BYTES);
      // word holds only check bytes: the end moves back one word
      strip = rx_line.valid && rx_line.eof && !passthru_ff &&
              (rx_line.nbytes <= FCS_BYTES);
      emit = hold_vld_ff && (rx_line.valid || hold_end_ff);
   end

   // frame accumulators; all rx logic on ref_clk, the one clock
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         crc_ff <= CRC_INIT;
         cnt_ff <= 16'h0000;
         len_ff <= 16'hFFFF;
         widx_ff <= 2'h0;
         rx_busy_ff <= 1'b0;
      end else if (ce && rx_line.valid) begin
         crc_ff <= nxt_crc;
         cnt_ff <= nxt_cnt;
         if (rx_line.sof) begin
            widx_ff <= LEN_WORD;
            len_ff <= 16'hFFFF;
         end else if (widx_ff == LEN_WORD) begin
            widx_ff <= widx_ff + 2'h1;
            len_ff <= {rx_line.data[8*LEN_HI_LANE+:8],
                       rx_line.data[8*LEN_LO_LANE+:8]};
         end
         rx_busy_ff <= !rx_line.eof;
      end
   end

   // one-word hold so the end marker can move back past the check
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hold_vld_ff <= 1'b0;
         hold_sof_ff <= 1'b0;
         hold_end_ff <= 1'b0;
         hold_empty_ff <= 3'h0;
         hold_err_ff <= 6'h00;
         hold_data_ff <= 64'h0000000000000000;
      end else if (ce) begin
         if (rx_line.valid && !strip) begin
            hold_vld_ff <= 1'b1;
            hold_data_ff <= rev(rx_line.data);
            hold_sof_ff <= rx_line.sof;
            hold_end_ff <= rx_line.eof;
            hold_err_ff <= rx_line.eof ? nxt_err : 6'h00;
            hold_empty_ff <= passthru_ff ?
                             3'(WORD_BYTES - rx_line.nbytes) :
                             3'(STRIP_BASE - rx_line.nbytes);
         end else if (strip || hold_end_ff) begin
            hold_vld_ff <= 1'b0;
            hold_end_ff <= 1'b0;
         end
      end
   end

   // client stream output; no backpressure, every word is final
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_out_ff <= '0;
      end else if (ce) begin
         rx_out_ff.rx_word_valid <= emit;
         rx_out_ff.rx_frame_start_marker <= emit && hold_sof_ff;
         rx_out_ff.rx_frame_end_marker <= emit &&
                                          (hold_end_ff || strip);
         rx_out_ff.rx_client_word <= hold_data_ff;
         if (emit && hold_end_ff) begin
            rx_out_ff.rx_unused_byte_count <= hold_empty_ff;
            rx_out_ff.rx_frame_error_vector <= hold_err_ff;
         end else if (emit && strip) begin
            rx_out_ff.rx_unused_byte_count <=
               3'(FCS_BYTES - rx_line.nbytes);
            rx_out_ff.rx_frame_error_vector <= nxt_err;
         end else begin
            rx_out_ff.rx_unused_byte_count <= 3'h0;
            rx_out_ff.rx_frame_error_vector <= 6'h00;
         end
      end
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst || !ce);

   property p_tx_kind;
      tx_info_valid |=> tx_frame_status_word[39:32] ==
         $past({tx_info.pfc, tx_info.unicast, tx_info.multicast,
                tx_info.broadcast, tx_info.pause, tx_info.control,
                tx_info.vlan, tx_info.stacked_vlan});
   endproperty
   a_tx_kind: assert property (p_tx_kind)
      else $error("tx status kind byte wrong");

   property p_tx_err;
      tx_info_valid |=> tx_frame_error_vector[6:3] == 4'h0 &&
         !tx_frame_error_vector[0] &&
         tx_frame_error_vector[TXE_LEN] == $past(tx_info.len_err);
   endproperty
   a_tx_err: assert property (p_tx_err)
      else $error("tx error vector wrong");

   property p_fc_rise;
      !two_bit_ff && flow_ctrl_request_low[0] && !prev_low_ff[0]
         |=> fc_xoff_pulse[0] && !fc_xon_pulse[0];
   endproperty
   a_fc_rise: assert property (p_fc_rise)
      else $error("rising request gave no xoff");

   property p_fc_fall;
      !two_bit_ff && !flow_ctrl_request_low[0] && prev_low_ff[0]
         |=> fc_xon_pulse[0];
   endproperty
   a_fc_fall: assert property (p_fc_fall)
      else $error("falling request gave no xon");

   property p_fc_ignore_high;
      !two_bit_ff && !flow_ctrl_request_low[0] && !prev_low_ff[0]
         |=> !fc_xon_pulse[0] && !fc_xoff_pulse[0];
   endproperty
   a_fc_ignore_high: assert property (p_fc_ignore_high)
      else $error("request with low input idle");

   property p_fc_two_bit;
      two_bit_ff && {flow_ctrl_request_high[0],
                     flow_ctrl_request_low[0]} == 2'b00
         |=> !fc_xon_pulse[0] && !fc_xoff_pulse[0] && !act_ff[0];
   endproperty
   a_fc_two_bit: assert property (p_fc_two_bit)
      else $error("code 00 did not stop requests");

   property p_rx_order;
      rx_line.valid && !rx_line.eof ##1 rx_line.valid
         |=> rx_out_ff.rx_client_word == rev($past(rx_line.data, 2));
   endproperty
   a_rx_order: assert property (p_rx_order)
      else $error("rx byte order wrong");

   property p_rx_valid;
      hold_vld_ff && rx_line.valid |=> rx_out_ff.rx_word_valid;
   endproperty
   a_rx_valid: assert property (p_rx_valid)
      else $error("rx valid dropped inside packet");

   property p_rx_sof;
      rx_out_ff.rx_frame_start_marker |-> rx_out_ff.rx_word_valid;
   endproperty
   a_rx_sof: assert property (p_rx_sof)
      else $error("start marker without valid");

   property p_rx_pass_end;
      rx_line.valid && rx_line.eof && passthru_ff |-> ##2
         rx_out_ff.rx_frame_end_marker &&
         rx_out_ff.rx_unused_byte_count ==
            3'(WORD_BYTES - $past(rx_line.nbytes, 2));
   endproperty
   a_rx_pass_end: assert property (p_rx_pass_end)
      else $error("pass-through end marker wrong");

   property p_rx_strip_end;
      strip && hold_vld_ff |=> rx_out_ff.rx_frame_end_marker &&
         rx_out_ff.rx_unused_byte_count ==
            3'(FCS_BYTES - $past(rx_line.nbytes));
   endproperty
   a_rx_strip_end: assert property (p_rx_strip_end)
      else $error("stripped end marker wrong");

   property p_rx_err_quiet;
      !rx_out_ff.rx_frame_end_marker |->
         rx_out_ff.rx_frame_error_vector == 6'h00;
   endproperty
   a_rx_err_quiet: assert property (p_rx_err_quiet)
      else $error("rx error outside end marker");

   property p_rx_malformed;
      rx_line.valid && rx_line.eof && rx_line.bad_term && passthru_ff
         |-> ##2 rx_out_ff.rx_frame_error_vector[RXE_MALF] &&
         rx_out_ff.rx_frame_error_vector[RXE_CRC];
   endproperty
   a_rx_malformed: assert property (p_rx_malformed)
      else $error("malformed frame not flagged");

   property p_rx_oversize;
      rx_line.valid && rx_line.eof && passthru_ff &&
         (nxt_cnt > maxlen_ff)
         |-> ##2 rx_out_ff.rx_frame_error_vector[RXE_OVER];
   endproperty
   a_rx_oversize: assert property (p_rx_oversize)
      else $error("oversized frame not flagged");

   c_one_bit_xoff: cover property (!two_bit_ff ##1 fc_xoff_pulse[0]);
   c_two_bit_xon: cover property (two_bit_ff ##1 fc_xon_pulse[0]);
   c_rx_strip: cover property (strip && hold_vld_ff);
   c_rx_crc_err: cover property (rx_out_ff.rx_frame_end_marker &&
      rx_out_ff.rx_frame_error_vector[RXE_CRC]);

endmodule

// >>> bench/mcsf_user_sink.sv
// user logic model: takes every client stream word, watches for gaps
module mcsf_user_sink
   import mcsf_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // client receive stream
   input wire mcsf_rx_stream_t rx_stream
);
   timeunit 1ns;
   timeprecision 1ps;
   mcsf_rx_stream_t got[$];
   int gaps = 0;
   logic in_f = 1'h0;
   // no backpressure exists, so nothing may be skipped or held off
   always @(posedge ref_clk) begin
      if (in_f && rx_stream.rx_word_valid !== 1'h1) begin
         gaps++;
      end
      if (rx_stream.rx_word_valid === 1'h1) begin
         got.push_back(rx_stream);
         in_f = rx_stream.rx_frame_start_marker |
            (in_f & ~rx_stream.rx_frame_end_marker);
      end
   end
endmodule

// >>> bench/test_mac_client_status_flow_rx_stream.sv
// self-checking bench of the mac client block
module test_mac_client_status_flow_rx_stream
   import mcsf_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst, ce, reg_wr, reg_rd, tx_v;
   logic [ADDR_W-1:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   mcsf_tx_info_t tx_info, last_i;
   logic [39:0] st;
   logic [6:0] te;
   logic [1:0] fc_lo, fc_hi, xoff_p, xon_p;
   mcsf_rx_line_t rx_line;
   mcsf_rx_stream_t rx_stream, exp_q[$];
   int miscompares = 0, n_compared = 0, n_xoff = 0, n_xon = 0, b;
   logic [15:0] seed = 16'h0058, maxlen = 16'h05EE;
   logic pt = 1'h1;

   mcsf_client #(.FLOW_QUEUE_COUNT(2)) uut (.ref_clk(ref_clk), .rst(rst),
      .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_info_valid(tx_v), .tx_info(tx_info),
      .tx_frame_status_word(st), .tx_frame_error_vector(te),
      .flow_ctrl_request_low(fc_lo), .flow_ctrl_request_high(fc_hi),
      .fc_xoff_pulse(xoff_p), .fc_xon_pulse(xon_p),
      .rx_line(rx_line), .rx_stream(rx_stream));
   mcsf_user_sink sink (.ref_clk(ref_clk), .rx_stream(rx_stream));

   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   // queue q pulses weigh 1 << q, so one sum tells the queues apart
   always @(posedge ref_clk) begin
      if (!rst) begin
         n_xoff += xoff_p;
         n_xon += xon_p;
      end
   end

   function automatic logic [7:0] rnd8();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction
   function automatic logic [31:0] crc8(logic [31:0] c, logic [7:0] x);
      c = c ^ {24'h0, x};
      for (int k = 0; k < 8; k++) begin
         c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   task automatic chk(logic [63:0] got, logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 v = reg_rdata;
   endtask
   task automatic tx_one();
      logic [47:0] r;
      mcsf_tx_info_t i;
      r = {rnd8(), rnd8(), rnd8(), rnd8(), rnd8(), rnd8()};
      i = r[41:0];
      last_i = i;
      @(posedge ref_clk);
      tx_info <= i;
      tx_v <= 1'h1;
      @(posedge ref_clk);
      tx_v <= 1'h0;
      #1;
      chk(st, {i.pfc, i.unicast, i.multicast, i.broadcast, i.pause,
         i.control, i.vlan, i.stacked_vlan, i.frame_len,
         i.payload_len});
      chk(te, {4'h0, i.len_err, i.oversize, 1'h0});
   endtask
   // xo below zero skips the xoff count where refresh may land
   task automatic fc(logic [1:0] hi, logic [1:0] lo, int xo, int xn);
      int b0, b1;
      b0 = n_xoff;
      b1 = n_xon;
      @(posedge ref_clk);
      fc_hi <= hi;
      fc_lo <= lo;
      repeat (4) @(posedge ref_clk);
      if (xo >= 0) chk(n_xoff - b0, xo);
      chk(n_xon - b1, xn);
   endtask
   task automatic frame(int nd, logic [15:0] lenf, logic bc, logic bt);
      logic [7:0] q[$];
      logic [31:0] c;
      logic [63:0] w, rw;
      logic [5:0] er;
      logic last;
      int n, nw, nl, ne;
      c = CRC_INIT;
      for (int k = 0; k < nd; k++) begin
         q.push_back(k == 12 ? lenf[15:8] : k == 13 ? lenf[7:0] : rnd8());
         c = crc8(c, q[k]);
      end
      c = ~c ^ {31'h0, bc};
      for (int k = 0; k < 4; k++) q.push_back(c[8*k +: 8]);
      er = {1'h0, lenf < 16'h0600 && nd + 4 < lenf + 18, nd + 4 > maxlen,
         1'h0, bc | bt, bt};
      nl = (q.size() + 7) / 8;
      // without pass-through the end marker sits on the last data byte
      ne = pt ? q.size() : nd;
      nw = (ne + 7) / 8;
      for (int j = 0; j < nl; j++) begin
         last = j == nl - 1;
         n = last ? q.size() - 8 * j : 8;
         w = 64'h0;
         for (int k = 0; k < n; k++) w[8*k +: 8] = q[8*j+k];
         for (int k = 0; k < 8; k++) rw[63-8*k -: 8] = w[8*k +: 8];
         if (j < nw) begin
            exp_q.push_back({1'h1, j == 0, j == nw - 1,
               j == nw - 1 ? 3'(8 * nw - ne) : 3'h0,
               j == nw - 1 ? er : 6'h0, rw});
         end
         @(posedge ref_clk);
         rx_line <= {1'h1, j == 0, last, bt && last, 4'(n), w};
      end
   endtask
   task automatic drain();
      mcsf_rx_stream_t g, e;
      @(posedge ref_clk);
      rx_line <= '0;
      repeat (6) @(posedge ref_clk);
      chk(sink.got.size(), exp_q.size());
      chk(sink.gaps, 0);
      while (exp_q.size() > 0 && sink.got.size() > 0) begin
         g = sink.got.pop_front();
         e = exp_q.pop_front();
         chk(g.rx_client_word, e.rx_client_word);
         chk(g[75:64], e[75:64]);
      end
   endtask

   initial begin
      #1000000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      rst = 1'h1;
      ce = 1'h1;
      {reg_wr, reg_rd, tx_v, reg_addr, reg_wdata} = '0;
      {fc_lo, fc_hi, tx_info, rx_line} = '0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'h0;
      rd(REG_MAXLEN, d);
      chk(d, 32'h05EE);
      rd(REG_REFRESH, d);
      chk(d, 32'h0FFF);
      rd(4'h2, d);
      chk(d, 32'h0);
      repeat (6) tx_one();
      // clock enable low: a status strobe must leave the outputs frozen
      @(posedge ref_clk);
      ce <= 1'h0;
      tx_v <= 1'h1;
      tx_info <= ~last_i;
      @(posedge ref_clk);
      ce <= 1'h1;
      tx_v <= 1'h0;
      #1 chk(st, last_i[41:2]);
      chk(te, {4'h0, last_i[1:0], 1'h0});
      fc(2'h0, 2'h1, 1, 0);
      fc(2'h3, 2'h1, 0, 0);
      fc(2'h0, 2'h0, 0, 1);
      fc(2'h0, 2'h2, 2, 0);
      fc(2'h0, 2'h0, 0, 2);
      wr(REG_REFRESH, 32'h10);
      // free-running timer takes the new period only at its next reload
      repeat (4100) @(posedge ref_clk);
      b = n_xoff;
      fc(2'h0, 2'h1, -1, 0);
      repeat (166) @(posedge ref_clk);
      chk((n_xoff - b) inside {[10:12]}, 1);
      rd(REG_STATUS, d);
      chk(d, 32'h1);
      fc(2'h0, 2'h0, -1, 1);
      wr(REG_REFRESH, 32'h0FFF);
      repeat (20) @(posedge ref_clk);
      wr(REG_CTRL, 32'h1);
      fc(2'h1, 2'h0, 1, 0);
      fc(2'h0, 2'h0, 0, 0);
      fc(2'h0, 2'h1, 0, 1);
      fc(2'h0, 2'h1, 0, 0);
      fc(2'h0, 2'h0, 0, 0);
      fc(2'h0, 2'h2, 0, 2);
      fc(2'h0, 2'h0, 0, 0);
      wr(REG_CTRL, 32'h2);
      frame(16, 16'h0800, 1'h0, 1'h0);
      frame(17, 16'h0800, 1'h1, 1'h0);
      frame(20, 16'h0800, 1'h0, 1'h1);
      frame(14, 16'h0040, 1'h0, 1'h0);
      drain();
      wr(REG_MAXLEN, 32'h13);
      maxlen = 16'h0013;
      rd(REG_MAXLEN, d);
      chk(d, 32'h13);
      frame(16, 16'h0800, 1'h0, 1'h0);
      frame(15, 16'h0800, 1'h0, 1'h0);
      drain();
      wr(REG_CTRL, 32'h0);
      pt = 1'h0;
      frame(16, 16'h0800, 1'h0, 1'h0);
      frame(21, 16'h0800, 1'h0, 1'h1);
      drain();
      tally_and_finish();
   end
endmodule
